// ---- src/adcs_top.sv ----
// Converter sequencer with input selection and conversion clock
`timescale 1ns/1ps

// Operation
// R01: Source codes 0000, 0100, 1100-1111 route an external pin.
// R02: Channel codes 0000-1011 connect analog pins 0-11.
// R03: Channel codes 1100-1111 connect no pin; input floats.
// R04: Internal source codes 0001-0011, 0101-0111 open every external switch.
// R05: 0001-0011 supply /1,/2,/4; 0101-0111 amplifier /1,/2,/4.
// R06: Source codes 10xx tie the converter input to ground.
// R07: Analog pin function disables other functions and pull-high.
// R08: Analog pin function overrides the port direction setting.
// R09: Start bit low-high-low begins one conversion.
// R10: Busy set when conversion starts, cleared when it completes.
// R11: Completion sets request flag; enabled interrupt pulses out.
// R12: Conversion clock is system clock divided by 1 to 128.
// R13: Software keeps conversion clock period in 0.5-10 us.
// R14: Software waits for settling after power-on before starting.
// R15: Four sampling clocks then twelve conversion clocks, sixteen total.
// R16: Conversion runs on its own without stalling the processor.
// R17: Software clears power-on when conversions are not needed.
// R18: Result registers hold while the converter is powered off.
// R19: Alignment 0 gives 11:4 high, 3:0 low; 1 gives 11:8, 7:0.
// R20: Result loads at end of sixteenth clock as busy clears.
module adcs_top
  import adcs_pkg::*;
#(
  parameter int NUM_PINS = 12,
  parameter int RES_BITS = 12
) (
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  converter_power_on_i,
  input  wire logic                  start_i,
  input  wire logic                  result_alignment_select_i,
  input  wire logic [3:0]            input_source_select_i,
  input  wire logic [3:0]            external_channel_select_i,
  input  wire logic [2:0]            conv_clock_divider_select_i,
  input  wire logic [2*NUM_PINS-1:0] pin_function_select_i,
  input  wire logic                  interrupt_enable_i,
  input  wire logic                  request_flag_clear_i,
  input  wire logic                  comparator_i,
  output logic                       conversion_busy_flag_o,
  output logic                       request_flag_o,
  output logic                       interrupt_o,
  output logic [7:0]                 result_high_byte_o,
  output logic [7:0]                 result_low_byte_o,
  output logic [NUM_PINS-1:0]        channel_switch_o,
  output logic [2:0]                 internal_source_o,
  output logic [1:0]                 internal_divide_o,
  output logic [NUM_PINS-1:0]        pin_is_analog_o,
  output logic                       conv_clock_o,
  output logic                       sample_o,
  output logic [RES_BITS-1:0]        sar_trial_o
);
`include "adcs_params.svh"

  initial begin
    if (RES_BITS != 12) $error("adcs_top: RES_BITS must be 12");
    if (NUM_PINS != 12) $error("adcs_top: NUM_PINS must be 12");
  end

  // ==========================================================================
  // State record
  typedef struct packed {
    adcs_state_t                 state;
    logic                        start_s1;
    logic                        start_s2;
    logic                        cmp_s1;
    logic                        cmp_s2;
    logic [4:0]                  clk_cnt;
    logic [RES_BITS-1:0]         sar;
    logic [3:0]                  bit_idx;
    logic                        busy;
    logic                        req;
    logic                        irq;
    logic [7:0]                  res_hi;
    logic [7:0]                  res_lo;
    logic [NUM_PINS-1:0]         sw;
    logic [2:0]                  src;
    logic [1:0]                  div;
    logic [NUM_PINS-1:0]         ana;
    logic                        cclk;
  } adcs_top_state_t;

  adcs_top_state_t st_ff;
  adcs_top_state_t nxt_st;

  logic                  tick;
  logic [NUM_PINS-1:0]   sw_dec;
  logic [2:0]            src_dec;
  logic [1:0]            div_dec;
  logic [NUM_PINS-1:0]   ana_dec;

  // ==========================================================================
  // Format the result into the register pair
  function automatic logic [15:0] adcs_format(input logic [11:0] d,
                                              input logic       right);
    if (right) begin
      adcs_format = {4'h0, d[11:8], d[7:0]};             // see R19
    end else begin
      adcs_format = {d[11:4], d[3:0], 4'h0};             // see R19
    end
  endfunction

  // ==========================================================================
  // Submodules
  adcs_clk_div #(
    .DIV_BITS (3)
  ) u_div (
    .clock_i   (clock_i),
    .reset_i   (reset_i),
    .run_i     (st_ff.busy),
    .div_sel_i (conv_clock_divider_select_i),
    .tick_o    (tick)
  );

  adcs_input_select #(
    .NUM_PINS (NUM_PINS)
  ) u_sel (
    .input_source_select_i     (input_source_select_i),
    .external_channel_select_i (external_channel_select_i),
    .pin_function_select_i     (pin_function_select_i),
    .channel_switch_o          (sw_dec),
    .internal_source_o         (src_dec),
    .internal_divide_o         (div_dec),
    .pin_is_analog_o           (ana_dec)
  );

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    logic [15:0] fmt;
    logic [RES_BITS-1:0] done_val;
    fmt      = '0;
    done_val = '0;
    nxt_st = st_ff;
    nxt_st.start_s1 = start_i;
    nxt_st.start_s2 = st_ff.start_s1;
    nxt_st.cmp_s1   = comparator_i;
    nxt_st.cmp_s2   = st_ff.cmp_s1;
    nxt_st.irq      = 1'b0;
    nxt_st.sw       = sw_dec;
    nxt_st.src      = src_dec;
    nxt_st.div      = div_dec;
    nxt_st.ana      = ana_dec;
    // Request flag: software clear loses to a new completion
    if (request_flag_clear_i) begin
      nxt_st.req = 1'b0;
    end
    case (st_ff.state)
      ADCS_IDLE: begin
        nxt_st.cclk = 1'b0;
        if (converter_power_on_i && st_ff.start_s2) begin
          nxt_st.state = ADCS_ARMED;                      // see R09
        end
      end
      ADCS_ARMED: begin
        if (!converter_power_on_i) begin
          nxt_st.state = ADCS_IDLE;
        end else if (!st_ff.start_s2) begin
          nxt_st.state   = ADCS_SAMPLE;                   // see R09 R16
          nxt_st.busy    = 1'b1;                          // see R10
          nxt_st.clk_cnt = 5'h00;
          nxt_st.sar     = {1'b1, {(RES_BITS-1){1'b0}}};
          nxt_st.bit_idx = 4'(RES_BITS - 1);
        end
      end
      ADCS_SAMPLE, ADCS_CONV: begin
        if (tick) begin
          nxt_st.cclk    = ~st_ff.cclk;
          nxt_st.clk_cnt = st_ff.clk_cnt + 5'h01;
          if (st_ff.clk_cnt + 5'h01 == `ADCS_SAMPLE_CLKS) begin
            nxt_st.state = ADCS_CONV;                     // see R15
          end
          if (st_ff.state == ADCS_CONV) begin
            // Resolve one bit per conversion clock
            done_val = st_ff.sar;
            if (!st_ff.cmp_s2) begin
              done_val[st_ff.bit_idx] = 1'b0;
            end
            if (st_ff.bit_idx != 4'h0) begin
              done_val[st_ff.bit_idx - 4'h1] = 1'b1;
            end
            nxt_st.sar     = done_val;
            nxt_st.bit_idx = st_ff.bit_idx - 4'h1;
          end
          if (st_ff.clk_cnt + 5'h01 == `ADCS_TOTAL_CLKS) begin
            nxt_st.state = ADCS_IDLE;                     // see R15
            nxt_st.busy  = 1'b0;                          // see R10 R20
            nxt_st.req   = 1'b1;                          // see R11
            nxt_st.irq   = interrupt_enable_i;            // see R11
            fmt = adcs_format(done_val, result_alignment_select_i);
            if (converter_power_on_i) begin               // see R18
              nxt_st.res_hi = fmt[15:8];                  // see R20
              nxt_st.res_lo = fmt[7:0];
            end
          end
        end
        if (!converter_power_on_i) begin
          nxt_st.state = ADCS_IDLE;                       // see R18
          nxt_st.busy  = 1'b0;
          nxt_st.cclk  = 1'b0;
        end
      end
      default: begin
        nxt_st.state = ADCS_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff        <= '0;
      st_ff.state  <= ADCS_IDLE;
      st_ff.src    <= ADCS_MUX_EXT;
      st_ff.res_hi <= 8'h00;
      st_ff.res_lo <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Outputs straight from the state register
  assign conversion_busy_flag_o = st_ff.busy;
  assign request_flag_o         = st_ff.req;
  assign interrupt_o            = st_ff.irq;
  assign result_high_byte_o     = st_ff.res_hi;
  assign result_low_byte_o      = st_ff.res_lo;
  assign channel_switch_o       = st_ff.sw;
  assign internal_source_o      = st_ff.src;
  assign internal_divide_o      = st_ff.div;
  assign pin_is_analog_o        = st_ff.ana;
  assign conv_clock_o           = st_ff.cclk;
  assign sample_o               = (st_ff.state == ADCS_SAMPLE);
  assign sar_trial_o            = st_ff.sar;

endmodule // adcs_top

// ---- common/adcs_params.svh ----
// Constants for the converter sequencer and input selection block
`ifndef ADCS_PARAMS_SVH
`define ADCS_PARAMS_SVH

// ==========================================================================
// Sequence timing in conversion clocks
`define ADCS_SAMPLE_CLKS   5'h04
`define ADCS_CONVERT_CLKS  5'h0C
`define ADCS_TOTAL_CLKS    5'h10

// ==========================================================================
// Input source codes
`define ADCS_SRC_SUPPLY1   4'h1
`define ADCS_SRC_SUPPLY2   4'h2
`define ADCS_SRC_SUPPLY4   4'h3
`define ADCS_SRC_EXT_A     4'h0
`define ADCS_SRC_EXT_B     4'h4
`define ADCS_SRC_AMP1      4'h5
`define ADCS_SRC_AMP2      4'h6
`define ADCS_SRC_AMP4      4'h7
`define ADCS_LAST_CHANNEL  4'hB

// ==========================================================================
// Pin function code that makes a pin an analog input
`define ADCS_PIN_FUNC_ANALOG 2'h3

// ==========================================================================
// Reset values
`define ADCS_RST_RESULT    12'h000
`define ADCS_RST_DIV       8'h00

`endif

// ---- common/adcs_pkg.sv ----
// Types shared by the converter sequencer and input selection block
package adcs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ADCS_IDLE   = 4'b0001,
    ADCS_ARMED  = 4'b0010,
    ADCS_SAMPLE = 4'b0100,
    ADCS_CONV   = 4'b1000
  } adcs_state_t;

  // Internal analog source steering
  typedef enum logic [2:0] {
    ADCS_MUX_EXT    = 3'h0,
    ADCS_MUX_SUPPLY = 3'h1,
    ADCS_MUX_AMP    = 3'h2,
    ADCS_MUX_GND    = 3'h3
  } adcs_mux_t;

endpackage

// ---- src/adcs_clk_div.sv ----
// Conversion clock tick generator, system clock divided by 2^code
`timescale 1ns/1ps
module adcs_clk_div
  import adcs_pkg::*;
#(
  parameter int DIV_BITS = 3
) (
  input  wire logic                clock_i,
  input  wire logic                reset_i,
  input  wire logic                run_i,
  input  wire logic [DIV_BITS-1:0] div_sel_i,
  output logic                     tick_o
);
`include "adcs_params.svh"

  initial begin
    if (DIV_BITS != 3) $error("adcs_clk_div: DIV_BITS must be 3");
  end

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } adcs_div_t;

  adcs_div_t st_ff;
  adcs_div_t nxt_st;

  // ==========================================================================
  // Divider: tick once every 2^code system clocks
  always_comb begin
    logic [7:0] last;
    last = 8'((9'h001 << div_sel_i) - 9'h001);
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (!run_i) begin
      nxt_st.cnt = `ADCS_RST_DIV;          // Restart phase on each run
    end else if (st_ff.cnt >= last) begin
      nxt_st.cnt  = `ADCS_RST_DIV;
      nxt_st.tick = 1'b1;                  // see R12
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule // adcs_clk_div

// ---- src/adcs_input_select.sv ----
// Analog input selection decode and pin function override
`timescale 1ns/1ps
module adcs_input_select
  import adcs_pkg::*;
#(
  parameter int NUM_PINS = 12
) (
  input  wire logic [3:0]            input_source_select_i,
  input  wire logic [3:0]            external_channel_select_i,
  input  wire logic [2*NUM_PINS-1:0] pin_function_select_i,
  output logic      [NUM_PINS-1:0]   channel_switch_o,
  output logic      [2:0]            internal_source_o,
  output logic      [1:0]            internal_divide_o,
  output logic      [NUM_PINS-1:0]   pin_is_analog_o
);
`include "adcs_params.svh"

  initial begin
    if (NUM_PINS != 12) $error("adcs_input_select: NUM_PINS must be 12");
  end

  // ==========================================================================
  // Source and channel decode
  always_comb begin
    logic ext;
    ext = (input_source_select_i == `ADCS_SRC_EXT_A) ||
          (input_source_select_i == `ADCS_SRC_EXT_B) ||
          (input_source_select_i[3:2] == 2'h3);          // see R01
    channel_switch_o  = '0;                              // see R04
    internal_source_o = ADCS_MUX_EXT;
    internal_divide_o = 2'h0;
    if (ext) begin
      if (external_channel_select_i <= `ADCS_LAST_CHANNEL) begin
        channel_switch_o[external_channel_select_i] = 1'b1; // see R02
      end                                                // see R03
    end else if (input_source_select_i[3:2] == 2'h2) begin
      internal_source_o = ADCS_MUX_GND;                  // see R06
    end else begin
      internal_source_o = input_source_select_i[2] ?
                          ADCS_MUX_AMP : ADCS_MUX_SUPPLY; // see R05
      internal_divide_o = input_source_select_i[1:0] - 2'h1;
    end
  end

  // ==========================================================================
  // Analog function overrides direction, pull-high and other functions
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_is_analog_o[i] = (pin_function_select_i[2*i +: 2] ==
                            `ADCS_PIN_FUNC_ANALOG);      // see R07 R08
    end
  end

endmodule // adcs_input_select

// ---- tb/adcs_assertions.sv ----
// Port checker for the converter sequencer block
`timescale 1ns/1ps
module adcs_assertions #(
  parameter int NUM_PINS = 12
) (
  input wire logic                  clock_i,
  input wire logic                  reset_i,
  input wire logic                  converter_power_on_i,
  input wire logic                  interrupt_enable_i,
  input wire logic [3:0]            input_source_select_i,
  input wire logic [3:0]            external_channel_select_i,
  input wire logic [2:0]            conv_clock_divider_select_i,
  input wire logic [2*NUM_PINS-1:0] pin_function_select_i,
  input wire logic                  conversion_busy_flag_o,
  input wire logic                  request_flag_o,
  input wire logic                  interrupt_o,
  input wire logic [7:0]            result_high_byte_o,
  input wire logic [7:0]            result_low_byte_o,
  input wire logic [NUM_PINS-1:0]   channel_switch_o,
  input wire logic [2:0]            internal_source_o,
  input wire logic [1:0]            internal_divide_o,
  input wire logic [NUM_PINS-1:0]   pin_is_analog_o
);
  // ==========================================================
  // Helper logic
  logic [11:0]         busy_cnt_ff;
  logic [11:0]         nxt_busy_cnt;
  logic [NUM_PINS-1:0] ana_mask;
  wire  [3:0]  src  = input_source_select_i;
  wire  [3:0]  ch   = external_channel_select_i;
  wire         busy = conversion_busy_flag_o;
  wire         ext  = src == 4'h0 || src == 4'h4 || src[3:2] == 2'h3;
  wire         none = channel_switch_o == '0;
  wire  [11:0] span = 12'h010 << conv_clock_divider_select_i;

  // Busy length counter and analog pin mask
  always_comb begin
    nxt_busy_cnt = busy ? busy_cnt_ff + 12'h001 : 12'h000;
    for (int i = 0; i < NUM_PINS; i++)
      ana_mask[i] = &pin_function_select_i[2*i +: 2];
  end

  // Counter register
  always_ff @(posedge clock_i) begin
    busy_cnt_ff <= reset_i ? 12'h000 : nxt_busy_cnt;
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // Powered conversion reaching its end
  sequence s_done;
    $fell(busy) && converter_power_on_i && $past(converter_power_on_i);
  endsequence

  ext_route_a: assert property (ext && ch <= 4'hB |=>
    channel_switch_o == (12'h001 << $past(ch)) && internal_source_o == 3'h0)
    else $error("external pin not routed");
  no_pin_a: assert property (ext && ch > 4'hB |=> none)
    else $error("switch closed for missing channel");
  int_open_a: assert property (src inside {[4'h1:4'h7]} && src != 4'h4 |=>
    none && internal_source_o == ($past(src[2]) ? 3'h2 : 3'h1)
    && internal_divide_o == $past(src[1:0]) - 2'h1)
    else $error("internal source decode wrong");
  gnd_tie_a: assert property (src[3:2] == 2'h2 |=>
    none && internal_source_o == 3'h3)
    else $error("ground source decode wrong");
  pin_analog_a: assert property (1'b1 |=> pin_is_analog_o == $past(ana_mask))
    else $error("analog pin function wrong");
  busy_span_a: assert property (s_done |->
    busy_cnt_ff >= span && busy_cnt_ff <= span + 12'h001)
    else $error("conversion length wrong");
  done_flag_a: assert property (s_done |->
    request_flag_o && interrupt_o == interrupt_enable_i)
    else $error("completion flag or interrupt wrong");
  irq_pulse_a: assert property (interrupt_o |=> !interrupt_o)
    else $error("interrupt longer than one cycle");
  irq_cause_a: assert property (interrupt_o |-> $fell(busy))
    else $error("interrupt without completion");
  result_hold_a: assert property (!$fell(busy) |->
    $stable(result_high_byte_o) && $stable(result_low_byte_o))
    else $error("result changed outside completion");
endmodule // adcs_assertions

bind adcs_top adcs_assertions #(.NUM_PINS(NUM_PINS)) u_adcs_assertions (
  .clock_i, .reset_i, .converter_power_on_i, .interrupt_enable_i,
  .input_source_select_i, .external_channel_select_i,
  .conv_clock_divider_select_i, .pin_function_select_i,
  .conversion_busy_flag_o, .request_flag_o, .interrupt_o,
  .result_high_byte_o, .result_low_byte_o, .channel_switch_o,
  .internal_source_o, .internal_divide_o, .pin_is_analog_o
);

// ---- tb/adcs_afe_model.sv ----
// Analog front end model: comparator against a held input level
`timescale 1ns/1ps
module adcs_afe_model (
  input  wire logic [11:0] sar_trial_i,
  input  wire logic [11:0] analog_level_i,
  output logic             comparator_o
);
  // Input at or above the trial word keeps the trial bit
  assign comparator_o = analog_level_i >= sar_trial_i;
endmodule // adcs_afe_model

// ---- tb/adcs_top_tb.sv ----
// Self-checking testbench for the converter sequencer block
`timescale 1ns/1ps
module adcs_top_tb;
  import adcs_pkg::*;
  logic        clock_i, reset_i, pwr, start, align, ien, fclr, cmp;
  logic [3:0]  src, chan;
  logic [2:0]  dv;
  logic [23:0] pfs;
  logic        busy, flag, irq, samp, cclk;
  logic [7:0]  hi, lo, eh, el;
  logic [11:0] sw, ana, trial, level, es;
  logic [2:0]  isrc;
  logic [1:0]  idiv;
  int          fails, cmp_count, n;

  adcs_top u_adcs_top (.clock_i(clock_i), .reset_i(reset_i),
    .converter_power_on_i(pwr), .start_i(start),
    .result_alignment_select_i(align), .input_source_select_i(src),
    .external_channel_select_i(chan), .conv_clock_divider_select_i(dv),
    .pin_function_select_i(pfs), .interrupt_enable_i(ien),
    .request_flag_clear_i(fclr), .comparator_i(cmp),
    .conversion_busy_flag_o(busy), .request_flag_o(flag),
    .interrupt_o(irq), .result_high_byte_o(hi), .result_low_byte_o(lo),
    .channel_switch_o(sw), .internal_source_o(isrc),
    .internal_divide_o(idiv), .pin_is_analog_o(ana), .conv_clock_o(cclk),
    .sample_o(samp), .sar_trial_o(trial));
  adcs_afe_model u_adcs_afe_model (.sar_trial_i(trial),
    .analog_level_i(level), .comparator_o(cmp));

  // Clock generator
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // ==========================================================
  // Tasks
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wait_busy(logic v, int lim);
    n = 0;
    while (busy !== v) begin
      if (n == lim) begin
        chk("busy wait", v, busy);
        test_done();
      end
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask

  task automatic kick(logic [2:0] d, logic al, logic ie);
    @(posedge clock_i);
    dv <= d;
    align <= al;
    ien <= ie;
    fclr <= 1'b1;
    start <= 1'b1;
    repeat (3) @(posedge clock_i);
    fclr <= 1'b0;
    start <= 1'b0;
    wait_busy(1'b1, 20);
  endtask

  task automatic convert(logic [2:0] d, logic al, logic ie);
    int e;
    e = 16 << d;
    kick(d, al, ie);
    chk("sampling phase", 1, samp);
    wait_busy(1'b0, 2200);
    chk("conv clock idle", 0, cclk);
    if (n == e + 1) n = e;
    chk("busy span", e, n);
    chk("request flag", 1, flag);
    chk("interrupt", ie, irq);
    eh = al ? {4'h0, level[11:8]} : level[11:4];
    el = al ? level[7:0] : {level[3:0], 4'h0};
    if (d >= 3'h3) begin
      chk("result high", eh, hi);
      chk("result low", el, lo);
    end
    repeat (20) @(posedge clock_i);
    #1 chk("no restart", 0, busy);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {pwr, start, align, ien, fclr, src, chan, dv, pfs} = '0;
    level = 12'h000;
    fails = 0;
    cmp_count = 0;
    reset_i = 1'b1;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    for (int s = 0; s < 16; s++) begin
      for (int c = 0; c < 16; c++) begin
        @(posedge clock_i);
        src <= s[3:0];
        chan <= c[3:0];
        @(posedge clock_i);
        #1;
        es = 12'h000;
        if ((s == 0 || s == 4 || s >= 12) && c < 12) es[c] = 1'b1;
        chk("switch", es, sw);
        chk("source", s[3] ? (s[2] ? 0 : 3) : (s == 0 || s == 4) ? 0
            : s[2] ? 2 : 1, isrc);
        if (s[2:0] != 0 && s != 4 && s < 8)
          chk("divide", s[1:0] - 1, idiv);
      end
    end
    $display("decode test done");
    foreach (es[p]) begin
      @(posedge clock_i);
      pfs <= 24'hB1E4C7 << (2 * p);
      @(posedge clock_i);
      #1;
      for (int i = 0; i < 12; i++) es[i] = &pfs[2*i +: 2];
      chk("pin analog", es, ana);
    end
    $display("pin function test done");
    @(posedge clock_i);
    pwr <= 1'b1;
    repeat (50) @(posedge clock_i);
    for (int d = 0; d < 8; d++) begin
      level = 12'h5A3 + d * 12'h111;
      convert(d[2:0], d[0], d[1]);
    end
    $display("conversion test done");
    level = 12'h3C6;
    kick(3'h6, 1'b0, 1'b1);
    repeat (100) @(posedge clock_i);
    pwr <= 1'b0;
    wait_busy(1'b0, 10);
    repeat (5) @(posedge clock_i);
    #1;
    chk("abort flag", 0, flag);
    chk("kept high", eh, hi);
    chk("kept low", el, lo);
    $display("power abort test done");
    test_done();
  end
endmodule // adcs_top_tb
